// ---- src/gcs_pkg.sv ----
// constants, types and helpers for the gate control serial slave
package gcs_pkg;

  // clock and enable-pin timing
  localparam int CLK_PERIOD_NS    = 20;
  localparam int EN_LOW_WAIT_NS   = 10000;
  localparam int EN_LOW_WAIT_CYC  = (EN_LOW_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // dead time range, linear over a 4-bit setting
  localparam int DT_MIN_NS        = 50;
  localparam int DT_MAX_NS        = 500;
  localparam int DT_STEPS         = 15;
  localparam int DT_STEP_NS       = (DT_MAX_NS - DT_MIN_NS) / DT_STEPS;
  localparam int DT_CNT_W         = 5;

  // serial frame layout
  localparam int FRAME_BITS       = 16;
  localparam int DATA_BITS        = 11;
  localparam logic [4:0] FRAME_BITS_CNT = 5'h10;
  localparam logic [4:0] FRAME_OVER_CNT = 5'h11;
  localparam logic       RW_WRITE   = 1'b0;
  localparam logic       RW_READ    = 1'b1;

  // serial register addresses and fields
  localparam logic [3:0] ADDR_STAT1 = 4'h0;
  localparam logic [3:0] ADDR_STAT2 = 4'h1;
  localparam logic [3:0] ADDR_CTRL1 = 4'h2;
  localparam logic [3:0] ADDR_CTRL2 = 4'h3;
  localparam int FAULT_SUM_BIT    = 10;
  localparam int STAT2_OV_BIT     = 7;
  localparam int GATE_RST_BIT     = 2;
  localparam logic [10:0] SREG_RST = 11'h000;

  // wishbone register offsets
  localparam logic [3:0] WB_ADR_DTIME = 4'h0;
  localparam logic [3:0] WB_ADR_STATE = 4'h4;

  typedef enum logic [1:0] {PW_OFF, PW_UP, PW_RUN, PW_HOLD} gcs_pwr_t;

  typedef struct packed {
    logic        rwFlag;
    logic [3:0]  addr;
    logic [10:0] data;
  } gcs_cmd_t;

  typedef struct packed {
    logic        frameFaultFlag;
    logic [3:0]  addr;
    logic [10:0] data;
  } gcs_resp_t;

  typedef struct packed {
    logic        gateEnable;
    logic        sclk;
    logic        sdi;
    logic        selN;
    logic        ovCond;
    logic [10:0] faultCond;
  } gcs_pins_t;

  typedef struct packed {
    logic [25:0] rsvd;
    logic        gatesOk;
    logic        ovLatch;
    logic        gateFault;
    logic        frameFault;
    logic [1:0]  pwr;
  } gcs_wbstat_t;

  localparam gcs_pins_t PINS_RST = '{selN: 1'b1, default: '0};

  function automatic logic [4:0] dtCycles(input logic [3:0] code);
    int ns;
    ns = DT_MIN_NS + int'(code) * DT_STEP_NS;
    return 5'((ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  endfunction

endpackage

// ---- src/gcs_gate_ctrl_spi_slave.sv ----
// gate driver control logic with serial slave and wishbone settings port
`timescale 1ns/1ps
`default_nettype none

module gcs_gate_ctrl_spi_slave
  import gcs_pkg::*;
#(
  parameter int         PHASES      = 3,
  parameter int         POWERUP_CYC = 16,
  parameter logic [3:0] DEVICE_ID   = 4'h5 // arbitrary value
)(
  input  wire logic              clock,
  input  wire logic              rst,
  input  wire logic              cyc_i,
  input  wire logic              stb_i,
  input  wire logic              we_i,
  input  wire logic [3:0]        adr_i,
  input  wire logic [31:0]       dat_i,
  input  wire logic [3:0]        sel_i,
  output logic      [31:0]       dat_o,
  output logic                   ack_o,
  input  wire logic              gateEnable,
  input  wire logic              serialClock,
  input  wire logic              serialDataIn,
  input  wire logic              serialSelectN,
  input  wire logic              gateSupplyOvervoltage,
  input  wire logic [10:0]       faultCondition,
  input  wire logic [PHASES-1:0] highSideInput,
  input  wire logic [PHASES-1:0] lowSideInput,
  output logic      [PHASES-1:0] highGateOutput,
  output logic      [PHASES-1:0] lowGateOutput,
  output logic                   serialDataOut,
  output logic                   serialDataOutOe,
  output logic                   gateDriverOn,
  output logic                   supportBlocksOn
);

  if (PHASES < 1 || POWERUP_CYC < 1 || POWERUP_CYC > 65535)
  begin : badParam
    $error("gcs_gate_ctrl_spi_slave: unsupported parameter value");
  end

  localparam logic [15:0] PU_LOAD   = 16'(POWERUP_CYC - 1);
  localparam logic [15:0] WAIT_LOAD = 16'(EN_LOW_WAIT_CYC);

  // two-flop synchronisers for every input except clock, rst and the wishbone port
  gcs_pins_t         pinRaw;
  gcs_pins_t         pinMeta_r;
  gcs_pins_t         pinSync_r;
  logic [PHASES-1:0] hiMeta_r;
  logic [PHASES-1:0] hiSync_r;
  logic [PHASES-1:0] loMeta_r;
  logic [PHASES-1:0] loSync_r;

  assign pinRaw = {gateEnable, serialClock, serialDataIn, serialSelectN,
                   gateSupplyOvervoltage, faultCondition};

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      pinMeta_r <= PINS_RST;
      pinSync_r <= PINS_RST;
      hiMeta_r  <= '0;
      hiSync_r  <= '0;
      loMeta_r  <= '0;
      loSync_r  <= '0;
    end
    else
    begin
      pinMeta_r <= pinRaw;
      pinSync_r <= pinMeta_r;
      hiMeta_r  <= highSideInput;
      hiSync_r  <= hiMeta_r;
      loMeta_r  <= lowSideInput;
      loSync_r  <= loMeta_r;
    end
  end

  // power sequencing on the enable pin
  gcs_pwr_t    pwr_r;
  gcs_pwr_t    pwr_nxt;
  logic [15:0] pwrCnt_r;
  logic [15:0] pwrCnt_nxt;
  logic        gateOn_r;
  logic        gateOn_nxt;
  logic        supOn_r;
  logic        supOn_nxt;
  logic        fullClr;
  logic        quickClr;
  logic        enS;

  assign enS = pinSync_r.gateEnable;

  always_comb
  begin
    pwr_nxt    = pwr_r;
    pwrCnt_nxt = pwrCnt_r;
    fullClr    = 1'b0;
    quickClr   = 1'b0;
    unique case (pwr_r)
      PW_OFF:
        if (enS)
        begin
          pwr_nxt    = PW_UP;
          pwrCnt_nxt = PU_LOAD;
          fullClr    = 1'b1;
        end
      PW_UP:
        if (!enS)
        begin
          pwr_nxt    = PW_HOLD;
          pwrCnt_nxt = WAIT_LOAD;
        end
        else if (pwrCnt_r == '0)
          pwr_nxt = PW_RUN;
        else
          pwrCnt_nxt = pwrCnt_r - 16'h0001;
      PW_RUN:
        if (!enS)
        begin
          pwr_nxt    = PW_HOLD;
          pwrCnt_nxt = WAIT_LOAD;
        end
      PW_HOLD:
        if (enS)
        begin
          // quick reset: support blocks never went down
          pwr_nxt    = PW_UP;
          pwrCnt_nxt = PU_LOAD;
          quickClr   = 1'b1;
        end
        else if (pwrCnt_r == '0)
        begin
          pwr_nxt = PW_OFF;
          fullClr = 1'b1;
        end
        else
          pwrCnt_nxt = pwrCnt_r - 16'h0001;
    endcase
    gateOn_nxt = (pwr_nxt == PW_RUN);
    supOn_nxt  = (pwr_nxt != PW_OFF);
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      pwr_r    <= PW_OFF;
      pwrCnt_r <= '0;
      gateOn_r <= 1'b0;
      supOn_r  <= 1'b0;
    end
    else
    begin
      pwr_r    <= pwr_nxt;
      pwrCnt_r <= pwrCnt_nxt;
      gateOn_r <= gateOn_nxt;
      supOn_r  <= supOn_nxt;
    end
  end

  // latched status and fault state
  logic [10:0] stat1_r;
  logic [10:0] stat1_nxt;
  logic        statOv_r;
  logic        statOv_nxt;
  logic        gateFault_r;
  logic        gateFault_nxt;
  logic        ovLatch_r;
  logic        ovLatch_nxt;
  logic        rdClr1;
  logic        rdClr2;
  logic        gateReset;
  logic [10:0] ctrl1_r;

  assign gateReset = ctrl1_r[GATE_RST_BIT];

  // a condition present in the clearing cycle sets the bit again
  always_comb
  begin
    stat1_nxt     = ((fullClr || quickClr || gateReset || rdClr1) ? SREG_RST : stat1_r)
                    | pinSync_r.faultCond;
    statOv_nxt    = ((fullClr || rdClr2) ? 1'b0 : statOv_r) | pinSync_r.ovCond;
    gateFault_nxt = ((fullClr || quickClr || gateReset) ? 1'b0 : gateFault_r)
                    | pinSync_r.faultCond[FAULT_SUM_BIT];
    ovLatch_nxt   = (fullClr ? 1'b0 : ovLatch_r) | pinSync_r.ovCond;
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      stat1_r     <= SREG_RST;
      statOv_r    <= 1'b0;
      gateFault_r <= 1'b0;
      ovLatch_r   <= 1'b0;
    end
    else
    begin
      stat1_r     <= stat1_nxt;
      statOv_r    <= statOv_nxt;
      gateFault_r <= gateFault_nxt;
      ovLatch_r   <= ovLatch_nxt;
    end
  end

  // serial slave, sampled on the system clock
  logic        selPrev_r;
  logic        sclkPrev_r;
  logic        inFrame_r;
  logic        inFrame_nxt;
  logic        startBad_r;
  logic        startBad_nxt;
  logic [4:0]  bitCnt_r;
  logic [4:0]  bitCnt_nxt;
  gcs_cmd_t    rx_r;
  gcs_cmd_t    rx_nxt;
  logic [15:0] tx_r;
  logic [15:0] tx_nxt;
  logic        sdoBit_r;
  logic        sdoBit_nxt;
  logic        sdoOe_r;
  logic        sdoOe_nxt;
  logic        pendFault_r;
  logic        pendFault_nxt;
  logic        lastRw_r;
  logic        lastRw_nxt;
  logic [3:0]  lastAddr_r;
  logic [3:0]  lastAddr_nxt;
  logic [10:0] ctrl1_nxt;
  logic [10:0] ctrl2_r;
  logic [10:0] ctrl2_nxt;
  logic [10:0] regData;
  gcs_resp_t   resp;
  logic        selS;
  logic        sclkS;
  logic        selFall;
  logic        selRise;
  logic        sclkRise;
  logic        sclkFall;
  logic        frameOk;

  assign selS     = pinSync_r.selN;
  assign sclkS    = pinSync_r.sclk;
  assign selFall  = selPrev_r && !selS;
  assign selRise  = !selPrev_r && selS;
  assign sclkRise = !sclkPrev_r && sclkS;
  assign sclkFall = sclkPrev_r && !sclkS;
  // clock low at both select edges and exactly sixteen bits
  assign frameOk  = !startBad_r && !sclkS && (bitCnt_r == FRAME_BITS_CNT);

  always_comb
  begin
    unique case (lastAddr_r)
      ADDR_STAT1: regData = stat1_r;
      ADDR_STAT2: regData = {3'h0, statOv_r, 3'h0, DEVICE_ID};
      ADDR_CTRL1: regData = ctrl1_r;
      ADDR_CTRL2: regData = ctrl2_r;
      default:    regData = SREG_RST;
    endcase
  end

  always_comb
  begin
    inFrame_nxt   = inFrame_r;
    startBad_nxt  = startBad_r;
    bitCnt_nxt    = bitCnt_r;
    rx_nxt        = rx_r;
    tx_nxt        = tx_r;
    sdoBit_nxt    = sdoBit_r;
    sdoOe_nxt     = sdoOe_r;
    pendFault_nxt = pendFault_r;
    lastRw_nxt    = lastRw_r;
    lastAddr_nxt  = lastAddr_r;
    ctrl1_nxt     = ctrl1_r;
    ctrl2_nxt     = ctrl2_r;
    rdClr1        = 1'b0;
    rdClr2        = 1'b0;
    // gate reset bit drops back once its pulse has been seen
    ctrl1_nxt[GATE_RST_BIT] = 1'b0;
    if (pendFault_r)
      resp = '{frameFaultFlag: 1'b1, addr: 4'h0, data: SREG_RST};
    else if (lastRw_r == RW_READ)
      resp = '{frameFaultFlag: 1'b0, addr: lastAddr_r, data: regData};
    else
      resp = '{frameFaultFlag: 1'b0, addr: ADDR_STAT1, data: stat1_r};
    if (!supOn_r)
    begin
      inFrame_nxt = 1'b0;
      sdoOe_nxt   = 1'b0;
    end
    else if (selFall)
    begin
      inFrame_nxt  = 1'b1;
      sdoOe_nxt    = 1'b1;
      bitCnt_nxt   = '0;
      startBad_nxt = sclkS;
      tx_nxt       = resp;
      sdoBit_nxt   = resp.frameFaultFlag;
      rdClr1       = !pendFault_r && (lastRw_r == RW_WRITE
                     || lastAddr_r == ADDR_STAT1);
      rdClr2       = !pendFault_r && lastRw_r == RW_READ
                     && lastAddr_r == ADDR_STAT2;
    end
    else if (inFrame_r && selRise)
    begin
      inFrame_nxt = 1'b0;
      sdoOe_nxt   = 1'b0;
      if (frameOk)
      begin
        pendFault_nxt = 1'b0;
        lastRw_nxt    = rx_r.rwFlag;
        lastAddr_nxt  = rx_r.addr;
        if (rx_r.rwFlag == RW_WRITE && rx_r.addr == ADDR_CTRL1)
          ctrl1_nxt = rx_r.data;
        if (rx_r.rwFlag == RW_WRITE && rx_r.addr == ADDR_CTRL2)
          ctrl2_nxt = rx_r.data;
      end
      else
        pendFault_nxt = 1'b1;
    end
    else if (inFrame_r)
    begin
      // edges only count inside a frame, so pauses cost nothing
      if (sclkRise)
      begin
        sdoBit_nxt = tx_r[FRAME_BITS-1];
        tx_nxt     = {tx_r[FRAME_BITS-2:0], 1'b0};
      end
      if (sclkFall)
      begin
        rx_nxt = {rx_r[FRAME_BITS-2:0], pinSync_r.sdi};
        if (bitCnt_r != FRAME_OVER_CNT)
          bitCnt_nxt = bitCnt_r + 5'h01;
      end
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      selPrev_r   <= 1'b1;
      sclkPrev_r  <= 1'b0;
      inFrame_r   <= 1'b0;
      startBad_r  <= 1'b0;
      bitCnt_r    <= '0;
      rx_r        <= '0;
      tx_r        <= '0;
      sdoBit_r    <= 1'b0;
      sdoOe_r     <= 1'b0;
      pendFault_r <= 1'b0;
      lastRw_r    <= RW_WRITE;
      lastAddr_r  <= ADDR_STAT1;
      ctrl1_r     <= SREG_RST;
      ctrl2_r     <= SREG_RST;
    end
    else
    begin
      selPrev_r   <= selS;
      sclkPrev_r  <= sclkS;
      inFrame_r   <= inFrame_nxt;
      startBad_r  <= startBad_nxt;
      bitCnt_r    <= bitCnt_nxt;
      rx_r        <= rx_nxt;
      tx_r        <= tx_nxt;
      sdoBit_r    <= sdoBit_nxt;
      sdoOe_r     <= sdoOe_nxt;
      pendFault_r <= pendFault_nxt;
      lastRw_r    <= lastRw_nxt;
      lastAddr_r  <= lastAddr_nxt;
      ctrl1_r     <= ctrl1_nxt;
      ctrl2_r     <= ctrl2_nxt;
    end
  end

  // wishbone slave, one wait state per access
  logic        ack_r;
  logic        ack_nxt;
  logic [31:0] datO_r;
  logic [31:0] datO_nxt;
  logic [3:0]  dtCode_r;
  logic [3:0]  dtCode_nxt;
  gcs_wbstat_t wbStat;
  logic        gatesOk;

  assign gatesOk = (pwr_r == PW_RUN) && !gateFault_r && !ovLatch_r;

  always_comb
  begin
    wbStat     = '{gatesOk: gatesOk, ovLatch: ovLatch_r, gateFault: gateFault_r,
                   frameFault: pendFault_r, pwr: pwr_r, default: '0};
    ack_nxt    = cyc_i && stb_i && !ack_r;
    datO_nxt   = datO_r;
    dtCode_nxt = dtCode_r;
    if (ack_nxt)
    begin
      unique case (adr_i)
        WB_ADR_DTIME: datO_nxt = {28'h0, dtCode_r};
        WB_ADR_STATE: datO_nxt = wbStat;
        default:      datO_nxt = 32'h0000_0000;
      endcase
      if (we_i && sel_i[0] && adr_i == WB_ADR_DTIME)
        dtCode_nxt = dat_i[3:0];
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      ack_r    <= 1'b0;
      datO_r   <= '0;
      dtCode_r <= '0;
    end
    else
    begin
      ack_r    <= ack_nxt;
      datO_r   <= datO_nxt;
      dtCode_r <= dtCode_nxt;
    end
  end

  // per-phase gate steering with break-before-make
  logic [DT_CNT_W-1:0] dtLoad;

  assign dtLoad = dtCycles(dtCode_r);

  for (genvar p = 0; p < PHASES; p++)
  begin : phase
    logic                hi_r;
    logic                hi_nxt;
    logic                lo_r;
    logic                lo_nxt;
    logic [DT_CNT_W-1:0] dt_r;
    logic [DT_CNT_W-1:0] dt_nxt;
    logic                wantHi;
    logic                wantLo;

    always_comb
    begin
      wantHi = gatesOk && hiSync_r[p] && !loSync_r[p];
      wantLo = gatesOk && loSync_r[p] && !hiSync_r[p];
      hi_nxt = hi_r;
      lo_nxt = lo_r;
      dt_nxt = dt_r;
      // a gate only turns on from both-off after the dead time expires
      if ((hi_r && !wantHi) || (lo_r && !wantLo))
      begin
        hi_nxt = 1'b0;
        lo_nxt = 1'b0;
        dt_nxt = dtLoad;
      end
      else if (dt_r != '0)
        dt_nxt = dt_r - 5'h01;
      else
      begin
        hi_nxt = wantHi;
        lo_nxt = wantLo;
      end
    end

    always_ff @(posedge clock or posedge rst)
    begin
      if (rst)
      begin
        hi_r <= 1'b0;
        lo_r <= 1'b0;
        dt_r <= '0;
      end
      else
      begin
        hi_r <= hi_nxt;
        lo_r <= lo_nxt;
        dt_r <= dt_nxt;
      end
    end

    assign highGateOutput[p] = hi_r;
    assign lowGateOutput[p]  = lo_r;
  end

  assign dat_o           = datO_r;
  assign ack_o           = ack_r;
  assign serialDataOut   = sdoBit_r;
  assign serialDataOutOe = sdoOe_r;
  assign gateDriverOn    = gateOn_r;
  assign supportBlocksOn = supOn_r;

endmodule

`default_nettype wire

// ---- dv/gcs_gate_ctrl_spi_slave_assertions.sv ----
// concurrent checks on the gate control serial slave ports
`timescale 1ns/1ps
`default_nettype none

module gcs_gate_ctrl_spi_slave_assertions #(
  parameter int PHASES = 3
)(
  input wire logic              clock,
  input wire logic              rst,
  input wire logic              gateEnable,
  input wire logic              serialClock,
  input wire logic              serialSelectN,
  input wire logic [PHASES-1:0] highSideInput,
  input wire logic [PHASES-1:0] highGateOutput,
  input wire logic [PHASES-1:0] lowGateOutput,
  input wire logic              serialDataOut,
  input wire logic              serialDataOutOe,
  input wire logic              supportBlocksOn
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  logic [9:0]             lowCnt_r;
  logic [3:0]             selHi_r;
  logic [3:0]             riseAge_r;
  logic                   sclkDly_r;
  logic                   onAtFall_r;
  logic [5:0][PHASES-1:0] hiHist_r;
  logic [PHASES-1:0]      hiAny;

  // input history covers sync and output register lag
  always_comb
  begin
    hiAny = highSideInput;
    for (int i = 0; i < 6; i++)
      hiAny = hiAny | hiHist_r[i];
  end

  always_ff @(posedge clock or posedge rst)
    if (rst)
    begin
      lowCnt_r   <= '0;
      selHi_r    <= '0;
      riseAge_r  <= '0;
      sclkDly_r  <= 1'b0;
      onAtFall_r <= 1'b0;
      hiHist_r   <= '0;
    end
    else
    begin
      lowCnt_r   <= gateEnable ? '0 : lowCnt_r + 10'(lowCnt_r != 10'h3FF);
      selHi_r    <= !serialSelectN ? '0 : selHi_r + 4'(selHi_r != 4'hF);
      riseAge_r  <= (serialClock && !sclkDly_r) ? '0 : riseAge_r + 4'(riseAge_r != 4'hF);
      sclkDly_r  <= serialClock;
      onAtFall_r <= (lowCnt_r == '0 && !gateEnable) ? supportBlocksOn : onAtFall_r;
      hiHist_r   <= {hiHist_r[4:0], highSideInput};
    end

  gate_excl_a: assert property ((highGateOutput & lowGateOutput) == '0)
    else $error("high and low gate on together");
  gate_cause_a: assert property ((highGateOutput & ~hiAny) == '0)
    else $error("high gate on without high input");
  dead_min_a: assert property ($fell(lowGateOutput[0]) |-> !highGateOutput[0] [*3])
    else $error("dead time too short");
  gate_stop_a: assert property ($fell(gateEnable) |-> ##[1:5] ((highGateOutput | lowGateOutput) == '0))
    else $error("gates not off after enable fall");
  off_quiet_a: assert property (!supportBlocksOn |-> !serialDataOutOe && highGateOutput == '0)
    else $error("output active while off");
  sel_hiz_a: assert property (selHi_r > 4'h5 |-> !serialDataOutOe)
    else $error("data out driven while deselected");
  sel_load_a: assert property ($fell(serialSelectN) && supportBlocksOn |-> ##[1:5] serialDataOutOe)
    else $error("data out not enabled on select");
  shift_edge_a: assert property (serialDataOutOe && $past(serialDataOutOe) && $changed(serialDataOut) |-> riseAge_r < 4'h6)
    else $error("reply bit changed away from rising clock");
  supp_hold_a: assert property (lowCnt_r == 10'h190 |-> supportBlocksOn == onAtFall_r)
    else $error("support blocks dropped too early");
  supp_off_a: assert property (lowCnt_r == 10'h258 |-> !supportBlocksOn)
    else $error("support blocks still on after long low");
endmodule

`default_nettype wire

// ---- dv/gcs_spi_master.sv ----
// serial master model that drives frames into the slave
`timescale 1ns/1ps
`default_nettype none

module gcs_spi_master (
  input  wire logic clock,
  input  wire logic serialDataOut,
  input  wire logic serialDataOutOe,
  output var logic  serialClock,
  output var logic  serialDataIn,
  output var logic  serialSelectN
);
  initial
  begin
    serialClock   = 1'b0;
    serialDataIn  = 1'b0;
    serialSelectN = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask

  // nb clocks of w msb first; a released data line reads as unknown
  task automatic frame(input logic [15:0] w, input int nb, output logic [15:0] r);
    r = '0;
    serialSelectN <= 1'b0;
    tick(6);
    for (int i = 0; i < nb; i++)
    begin
      serialDataIn <= w[15-i];
      serialClock  <= 1'b1;
      tick(4);
      r = {r[14:0], serialDataOutOe ? serialDataOut : 1'bx};
      serialClock  <= 1'b0;
      tick(4);
      if (i == 7)
        tick(30);
    end
    serialDataIn  <= ~serialDataIn;
    serialSelectN <= 1'b1;
    tick(8);
  endtask
endmodule

`default_nettype wire

// ---- dv/gcs_gate_ctrl_spi_slave_bench.sv ----
// self-checking bench for the gate control serial slave
`timescale 1ns/1ps
`default_nettype none

module gcs_gate_ctrl_spi_slave_bench;
  logic        clock, rst, cyc_i, stb_i, we_i, ack_o, gateEnable;
  logic [3:0]  adr_i, sel_i;
  logic [31:0] dat_i, dat_o, q;
  logic        serialClock, serialDataIn, serialSelectN, serialDataOut, serialDataOutOe;
  logic        gateSupplyOvervoltage, gateDriverOn, supportBlocksOn;
  logic [10:0] faultCondition;
  logic [2:0]  highSideInput, lowSideInput, highGateOutput, lowGateOutput;
  logic [15:0] r;
  int          errCount;
  int          nChecks;

  gcs_gate_ctrl_spi_slave #(.POWERUP_CYC(4)) gcs_gate_ctrl_spi_slave_i (
    .clock, .rst, .cyc_i, .stb_i, .we_i, .adr_i, .dat_i, .sel_i, .dat_o, .ack_o,
    .gateEnable, .serialClock, .serialDataIn, .serialSelectN, .gateSupplyOvervoltage,
    .faultCondition, .highSideInput, .lowSideInput, .highGateOutput, .lowGateOutput,
    .serialDataOut, .serialDataOutOe, .gateDriverOn, .supportBlocksOn);
  gcs_spi_master gcs_spi_master_i (
    .clock, .serialDataOut, .serialDataOutOe, .serialClock, .serialDataIn, .serialSelectN);

  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nChecks++;
    if (got !== exp)
    begin
      errCount++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic endSim();
    if (errCount == 0 && nChecks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // classic cycle; data taken at the ack edge only
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= 4'hF;
    // only the watchdog ends a missing answer
    do
    begin
      @(posedge clock);
    end
    while (ack_o !== 1'b1);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clock);
  endtask

  task automatic frm(input logic [15:0] w, input int nb);
    gcs_spi_master_i.frame(w, nb, r);
  endtask

  task automatic waitOn();
    while (gateDriverOn !== 1'b1)
    begin
      @(posedge clock);
    end
    cyc(40);
  endtask

  // short low keeps support alive
  task automatic toggle();
    gateEnable <= 1'b0;
    cyc(50);
    chk(32'(gateDriverOn), 0);
    chk(32'(supportBlocksOn), 1);
    gateEnable <= 1'b1;
    cyc(8);
    waitOn();
  endtask

  task automatic tPower();
    gateEnable <= 1'b1;
    waitOn();
    chk(32'(supportBlocksOn), 1);
    chk(32'(highGateOutput), 7);
  endtask

  task automatic tRegs();
    wb(1'b1, 4'h0, 32'h0000000F);
    wb(1'b0, 4'h0, 32'h0);
    chk(q, 32'h0000000F);
    wb(1'b0, 4'h8, 32'h0);
    chk(q, 32'h0);
    wb(1'b0, 4'h4, 32'h0);
    chk(32'(q[1:0]), 2);
    wb(1'b1, 4'h0, 32'h0);
  endtask

  task automatic tGates();
    for (int k = 0; k < 4; k++)
    begin
      highSideInput <= {3{k[1]}};
      lowSideInput  <= {3{k[0]}};
      cyc(40);
      chk(32'({highGateOutput, lowGateOutput}), 32'({{3{k[1] & ~k[0]}}, {3{k[0] & ~k[1]}}}));
    end
  endtask

  task automatic tSpi();
    frm(16'h8800, 16);
    frm(16'h18A9, 16);
    chk(32'(r), 32'h0805);
    frm(16'h9800, 16);
    chk(32'(r), 32'h0);
    frm(16'h9800, 16);
    chk(32'(r), 32'h18A9);
    frm(16'h1FFF, 15);
    frm(16'h8000, 16);
    chk(32'(r), 32'h8000);
    frm(16'h8000, 16);
    chk(32'(r), 32'h0);
    faultCondition <= 11'h008;
    cyc(4);
    faultCondition <= 11'h000;
    frm(16'h8000, 16);
    chk(32'(r), 32'h0008);
    frm(16'h9800, 16);
    chk(32'(r), 32'h0000);
    frm(16'h9800, 16);
    chk(32'(r), 32'h18A9);
  endtask

  task automatic tFault();
    highSideInput <= 3'h7;
    lowSideInput  <= 3'h0;
    faultCondition <= 11'h400;
    cyc(40);
    chk(32'(highGateOutput), 0);
    toggle();
    chk(32'(highGateOutput), 0);
    faultCondition <= 11'h000;
    toggle();
    chk(32'(highGateOutput), 7);
    faultCondition <= 11'h400;
    cyc(4);
    faultCondition <= 11'h000;
    frm(16'h1004, 16);
    cyc(40);
    chk(32'({supportBlocksOn, highGateOutput}), 32'hF);
  endtask

  task automatic tOv();
    gateSupplyOvervoltage <= 1'b1;
    cyc(4);
    gateSupplyOvervoltage <= 1'b0;
    frm(16'h1004, 16);
    toggle();
    wb(1'b0, 4'h4, 32'h0);
    chk(32'({q[4], highGateOutput}), 32'h8);
    gateEnable <= 1'b0;
    cyc(700);
    chk(32'({supportBlocksOn, highGateOutput}), 0);
    frm(16'h8800, 16);
    gateEnable <= 1'b1;
    waitOn();
    wb(1'b0, 4'h4, 32'h0);
    chk(32'({q[4], highGateOutput}), 32'h7);
  endtask

  initial
  begin
    cyc(30000);
    errCount++;
    endSim();
  end

  initial
  begin
    errCount = 0;
    nChecks = 0;
    rst = 1'b1;
    {cyc_i, stb_i, we_i, gateEnable, gateSupplyOvervoltage} = '0;
    adr_i = 4'h0;
    sel_i = 4'hF;
    dat_i = 32'h0;
    faultCondition = 11'h000;
    highSideInput = 3'h7;
    lowSideInput = 3'h0;
    cyc(20);
    rst <= 1'b0;
    tPower();
    tRegs();
    tGates();
    tSpi();
    tFault();
    tOv();
    endSim();
  end
endmodule

bind gcs_gate_ctrl_spi_slave gcs_gate_ctrl_spi_slave_assertions #(.PHASES(PHASES)) gcs_chk_i (
  .clock, .rst, .gateEnable, .serialClock, .serialSelectN, .highSideInput, .highGateOutput,
  .lowGateOutput, .serialDataOut, .serialDataOutOe, .supportBlocksOn);

`default_nettype wire
